// *** verilog/sdcad_top.sv ***
/*
  Command, address and control input front end of a memory die:
  sampling, command decode, power-down gating, termination, write mask,
  parity check with alert, reset and test entry.
  Assumes pins arrive unsynchronised; mask beats and bank status come
  from logic on clk; mode settings are quasi-static.
*/
//
// Behaviour
// - sample all inputs on rising clock
// - chip select high masks the command
// - command from cs, act and three lines
// - activate uses three lines as A16..A14
// - act high makes lines command code
// - bank bits select bank or register
// - group bits select group; x16 drops BG1
// - stack inputs: chip ID or second die
// - cke low enters power-down or self refresh
// - self refresh exit watched on cke alone
// - power-down and self refresh gate receivers
// - low mask discards write beat per lane
// - mask and termination strobe need enabling
// - odt turns on termination unless disabled or in self refresh
// - parity covers command, address, bank, and chip ID in 3DS stacking
// - unused address pins count as zero
// - parity only when chip select low
// - reset pin low holds device reset
// - test enable high enters connectivity test
// - A10 selects auto precharge, all banks
// - A12 low chops the burst
// - parity error drives alert low
`timescale 1ns/100ps
`include "sdcad_defines.svh"
module sdcad_top #(
  parameter int          DEV_WIDTH = 8,
  parameter logic [17:0] ADDR_USED = `SDCAD_ADDR_USED
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // command, address and control pins
  input  wire logic                  cs_n,
  input  wire logic                  act_n,
  input  wire logic                  ras_n,
  input  wire logic                  cas_n,
  input  wire logic                  we_n,
  input  wire logic                  a17,
  input  wire logic [13:0]           addr,
  input  wire logic [1:0]            bg,
  input  wire logic [1:0]            ba,
  input  wire logic [2:0]            cid,
  input  wire logic                  cke,
  input  wire logic                  odt,
  input  wire logic                  par,
  input  wire logic                  reset_n,
  input  wire logic                  ten,
  // write beats from the data capture path
  input  wire logic                  wr_beat,
  input  wire logic [1:0]            wr_dm_n,
  // mode settings and bank status
  input  wire logic                  cfg_par_en,
  input  wire logic                  cfg_rtt_en,
  input  wire logic                  cfg_dm_en,
  input  wire logic                  cfg_tdqs_en,
  input  sdcad_pkg::sdcad_stack_t    cfg_stack,
  input  wire logic [2:0]            cfg_die_id,
  input  wire logic                  cfg_ddp_die,
  input  wire logic                  any_bank_open,
  // decoded command
  output logic                       cmd_valid,
  output sdcad_pkg::sdcad_cmd_t      cmd,
  output logic [1:0]                 cmd_bg,
  output logic [1:0]                 cmd_ba,
  output logic [17:0]                cmd_addr,
  output logic                       cmd_auto_pre,
  output logic                       cmd_all_banks,
  output logic                       cmd_burst_chop,
  // power state and gating
  output sdcad_pkg::sdcad_pwr_t      pwr_state,
  output logic                       int_clk_en,
  output logic                       in_buf_en,
  output logic                       out_drv_en,
  // termination, mask, alert, test
  output logic                       odt_on,
  output logic                       tdqs_term_on,
  output logic [1:0]                 beat_keep,
  output logic                       par_err,
  output logic                       alert_n,
  output logic                       test_mode,
  output logic                       dev_in_reset
);
  sdcad_pkg::sdcad_state_t q;
  sdcad_pkg::sdcad_state_t d;
  sdcad_par_if             pif ();

  logic                    dev_rst;
  logic                    stk_on;
  logic                    cs_eff;
  logic                    cke_eff;
  logic                    odt_eff;
  logic                    id_ok;
  logic                    recv_cmd;
  logic                    sel;
  logic                    cke_run;
  logic                    mask_on;
  logic [1:0]              bg_m;
  sdcad_pkg::sdcad_cmd_t   dec;

  sdcad_par_chk u_par (
    .pif (pif.chk)
  );

  always_comb begin
    d         = q;
    d.s1      = '{cs_n: cs_n, act_n: act_n, ras_n: ras_n, cas_n: cas_n, we_n: we_n,
                  a17: a17, addr: addr, bg: bg, ba: ba, cid: cid, cke: cke,
                  odt: odt, par: par};
    d.cw      = q.s1;
    d.rstn_s1 = reset_n;
    d.rstn_s2 = q.rstn_s1;
    d.ten_s1  = ten;
    d.ten_s2  = q.ten_s1;
    dev_rst   = ~q.rstn_s2;

    // stacking: x16 parts ignore the stack inputs
    stk_on  = DEV_WIDTH != 16;
    cs_eff  = q.cw.cs_n;
    cke_eff = q.cw.cke;
    odt_eff = q.cw.odt;
    if (stk_on && cfg_stack == sdcad_pkg::STK_DDP && cfg_ddp_die) begin
      cs_eff  = q.cw.cid[1];
      cke_eff = q.cw.cid[0];
      odt_eff = q.cw.cid[2];
    end
    id_ok = !(stk_on && cfg_stack == sdcad_pkg::STK_3DS) || q.cw.cid == cfg_die_id;
    bg_m  = {q.cw.bg[1] & (DEV_WIDTH != 16), q.cw.bg[0]};

    // only the clock, odt, reset, ten and cke receivers stay on outside normal power
    recv_cmd = q.pwr == sdcad_pkg::PWR_ON;

    pif.cw        = q.cw;
    pif.cw.bg     = bg_m;
    pif.cs_eff    = cs_eff | ~recv_cmd | q.test_mode;
    pif.chk_en    = cfg_par_en;
    pif.use_cid   = stk_on && cfg_stack == sdcad_pkg::STK_3DS;
    pif.addr_used = ADDR_USED;

    sel     = ~cs_eff & id_ok & recv_cmd & ~q.test_mode & ~pif.err;
    cke_run = q.cke_prev & cke_eff;

    if (!q.cw.act_n) begin
      dec = sdcad_pkg::CMD_ACT;
    end else begin
      unique case ({q.cw.ras_n, q.cw.cas_n, q.cw.we_n})
        `SDCAD_RCW_MRS: dec = sdcad_pkg::CMD_MRS;
        `SDCAD_RCW_REF: dec = sdcad_pkg::CMD_REF;
        `SDCAD_RCW_PRE: dec = sdcad_pkg::CMD_PRE;
        `SDCAD_RCW_RFU: dec = sdcad_pkg::CMD_RFU;
        `SDCAD_RCW_WR:  dec = sdcad_pkg::CMD_WR;
        `SDCAD_RCW_RD:  dec = sdcad_pkg::CMD_RD;
        `SDCAD_RCW_ZQC: dec = sdcad_pkg::CMD_ZQC;
        `SDCAD_RCW_NOP: dec = sdcad_pkg::CMD_NOP;
      endcase
    end

    // commands only while cke stays high across the edge
    d.cmd_valid = sel & cke_run;
    if (sel && cke_run) begin
      d.cmd = dec;
      d.bg  = bg_m;
      d.ba  = q.cw.ba;
      if (!q.cw.act_n) begin
        d.addr = {q.cw.a17, q.cw.ras_n, q.cw.cas_n, q.cw.we_n, q.cw.addr};
      end else begin
        d.addr = {q.cw.a17, 3'h0, q.cw.addr};
      end
      d.auto_pre  = (dec == sdcad_pkg::CMD_RD || dec == sdcad_pkg::CMD_WR)
                    && q.cw.addr[`SDCAD_AP_BIT];
      d.all_banks = dec == sdcad_pkg::CMD_PRE && q.cw.addr[`SDCAD_AP_BIT];
      d.bc        = (dec == sdcad_pkg::CMD_RD || dec == sdcad_pkg::CMD_WR)
                    && !q.cw.addr[`SDCAD_BC_BIT];
    end
    d.cke_prev = cke_eff;

    // power state
    unique case (q.pwr)
      sdcad_pkg::PWR_ON: begin
        if (q.cke_prev && !cke_eff) begin
          if (sel && dec == sdcad_pkg::CMD_REF && !any_bank_open) begin
            d.pwr = sdcad_pkg::PWR_SR;
          end else if (any_bank_open) begin
            d.pwr = sdcad_pkg::PWR_APD;
          end else begin
            d.pwr = sdcad_pkg::PWR_PPD;
          end
        end
      end
      sdcad_pkg::PWR_PPD, sdcad_pkg::PWR_APD: begin
        if (cke_eff) begin
          d.pwr = sdcad_pkg::PWR_ON;
        end
      end
      sdcad_pkg::PWR_SR: begin
        if (cke_eff) begin
          d.pwr = sdcad_pkg::PWR_ON;
        end
      end
    endcase

    // termination follows odt unless disabled or in self refresh
    d.odt_on  = odt_eff & cfg_rtt_en & (q.pwr != sdcad_pkg::PWR_SR);
    d.tdqs_on = d.odt_on & cfg_tdqs_en & (DEV_WIDTH == 8);

    // write mask: x4 has none; x8 loses it to the termination strobe
    mask_on = cfg_dm_en & (DEV_WIDTH != 4) & ~(cfg_tdqs_en & (DEV_WIDTH == 8));
    d.keep[0] = wr_beat & (wr_dm_n[0] | ~mask_on);
    d.keep[1] = wr_beat & (DEV_WIDTH == 16) & (wr_dm_n[1] | ~mask_on);

    d.par_err = pif.err;
    if (pif.err) begin
      d.alert_cnt = `SDCAD_ALERT_PW;
    end else if (q.alert_cnt != 4'h0) begin
      d.alert_cnt = q.alert_cnt - 4'h1;
    end

    d.test_mode = q.ten_s2;

    if (dev_rst) begin
      d.pwr       = sdcad_pkg::PWR_ON;
      d.cmd_valid = 1'b0;
      d.cke_prev  = 1'b0;
      d.odt_on    = 1'b0;
      d.tdqs_on   = 1'b0;
      d.keep      = 2'h0;
      d.par_err   = 1'b0;
      d.alert_cnt = 4'h0;
      d.test_mode = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q    <= '0;
      q.s1 <= `SDCAD_CW_IDLE;
      q.cw <= `SDCAD_CW_IDLE;
    end else begin
      q <= d;
    end
  end

  assign cmd_valid      = q.cmd_valid;
  assign cmd            = q.cmd;
  assign cmd_bg         = q.bg;
  assign cmd_ba         = q.ba;
  assign cmd_addr       = q.addr;
  assign cmd_auto_pre   = q.auto_pre;
  assign cmd_all_banks  = q.all_banks;
  assign cmd_burst_chop = q.bc;
  assign pwr_state      = q.pwr;
  assign int_clk_en     = q.pwr == sdcad_pkg::PWR_ON;
  assign in_buf_en      = q.pwr == sdcad_pkg::PWR_ON;
  assign out_drv_en     = q.pwr == sdcad_pkg::PWR_ON;
  assign odt_on         = q.odt_on;
  assign tdqs_term_on   = q.tdqs_on;
  assign beat_keep      = q.keep;
  assign par_err        = q.par_err;
  assign alert_n        = q.alert_cnt == 4'h0;
  assign test_mode      = q.test_mode;
  assign dev_in_reset   = ~q.rstn_s2;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || !q.rstn_s2);

  AST_CS_MASK: assert property (
    (q.cw.cs_n && cfg_stack == sdcad_pkg::STK_NONE) |=> !cmd_valid)
    else $error("command taken with chip select high");
  AST_ACT_ROW: assert property (
    (cmd_valid && cmd == sdcad_pkg::CMD_ACT) |->
      !$past(q.cw.act_n) && cmd_addr[16:14] == $past({q.cw.ras_n, q.cw.cas_n, q.cw.we_n}))
    else $error("activate row bits wrong");
  AST_WR_CODE: assert property (
    (cmd_valid && cmd == sdcad_pkg::CMD_WR) |->
      $past({q.cw.act_n, q.cw.ras_n, q.cw.cas_n, q.cw.we_n}) == {1'b1, `SDCAD_RCW_WR})
    else $error("write decoded from wrong code");
  AST_BANK: assert property (
    cmd_valid |-> cmd_ba == $past(q.cw.ba))
    else $error("bank address not carried");
  AST_BG16: assert property (
    cmd_valid |-> (DEV_WIDTH != 16 || !cmd_bg[1]))
    else $error("upper bank group used on x16");
  AST_APD: assert property (
    $rose(q.pwr == sdcad_pkg::PWR_APD) |-> $past(any_bank_open) && !$past(cke_eff))
    else $error("active power-down without open row");
  AST_GATE: assert property (
    (q.pwr != sdcad_pkg::PWR_ON) |=> !cmd_valid && !par_err)
    else $error("command received while gated");
  AST_SR_ODT: assert property (
    (q.pwr == sdcad_pkg::PWR_SR) |=> !odt_on)
    else $error("termination on in self refresh");
  AST_ODT_DIS: assert property (
    !cfg_rtt_en |=> !odt_on)
    else $error("termination on while disabled");
  AST_MASK: assert property (
    (wr_beat && mask_on && !wr_dm_n[0]) |=> !beat_keep[0])
    else $error("masked beat kept");
  AST_PAR_CS: assert property (
    (q.cw.cs_n && cfg_stack == sdcad_pkg::STK_NONE) |=> !par_err)
    else $error("parity checked with chip select high");
  AST_ALERT: assert property (
    par_err |-> !alert_n [*6])
    else $error("alert shorter than its width");
  AST_AP: assert property (
    (cmd_valid && cmd == sdcad_pkg::CMD_PRE) |-> cmd_all_banks == cmd_addr[10])
    else $error("precharge all does not follow A10");
  AST_BC: assert property (
    (cmd_valid && cmd == sdcad_pkg::CMD_RD) |-> cmd_burst_chop == !cmd_addr[12])
    else $error("burst chop does not follow A12");
  AST_TEN: assert property (
    q.test_mode |=> !cmd_valid)
    else $error("command taken in test mode");
  AST_RESET: assert property (@(posedge clk) disable iff (rst)
    !q.rstn_s2 |=> !cmd_valid && alert_n && dev_in_reset == !$past(q.rstn_s1))
    else $error("decoder active in reset");

  COV_ACT: cover property (cmd_valid && cmd == sdcad_pkg::CMD_ACT);
  COV_SR: cover property ($rose(q.pwr == sdcad_pkg::PWR_SR));
  COV_PAR: cover property (par_err);
  COV_ODT: cover property (odt_on && tdqs_term_on);
endmodule

// *** common/sdcad_defines.svh ***
/*
  Constants of the command and address input decoder: reset values,
  command codes on the shared lines, address bit positions and counts.
  Assumes inclusion by bare name from the decoder's files.
*/
`ifndef SDCAD_DEFINES_SVH
`define SDCAD_DEFINES_SVH

// address pins present on this density, one bit per pin A17..A0
`define SDCAD_ADDR_USED 18'h3FFFF
// command word with every active-low line idle
`define SDCAD_CW_IDLE   30'h3E000000
// cycles that the alert output stays low after a parity error
`define SDCAD_ALERT_PW  4'h6

// ras_n, cas_n, we_n codes while act_n is high
`define SDCAD_RCW_MRS   3'h0
`define SDCAD_RCW_REF   3'h1
`define SDCAD_RCW_PRE   3'h2
`define SDCAD_RCW_RFU   3'h3
`define SDCAD_RCW_WR    3'h4
`define SDCAD_RCW_RD    3'h5
`define SDCAD_RCW_ZQC   3'h6
`define SDCAD_RCW_NOP   3'h7

// address bits with a second meaning
`define SDCAD_AP_BIT    10
`define SDCAD_BC_BIT    12

`endif

// *** common/sdcad_pkg.sv ***
/*
  Types of the command and address input decoder: commands, power
  states, stack modes, the sampled command word and the decoder state.
  Assumes nothing of its surroundings.
*/
package sdcad_pkg;

  typedef enum logic [3:0] {
    CMD_ACT, CMD_MRS, CMD_REF, CMD_PRE, CMD_RFU, CMD_WR, CMD_RD, CMD_ZQC, CMD_NOP
  } sdcad_cmd_t;

  typedef enum logic [1:0] {PWR_ON, PWR_PPD, PWR_APD, PWR_SR} sdcad_pwr_t;

  typedef enum logic [1:0] {STK_NONE, STK_DDP, STK_3DS} sdcad_stack_t;

  // one sample of the command, address and control pins except reset_n and ten
  typedef struct packed {
    logic        cs_n;
    logic        act_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic        a17;
    logic [13:0] addr;
    logic [1:0]  bg;
    logic [1:0]  ba;
    logic [2:0]  cid;
    logic        cke;
    logic        odt;
    logic        par;
  } sdcad_cw_t;

  typedef struct packed {
    sdcad_cw_t  s1;
    sdcad_cw_t  cw;
    logic       rstn_s1;
    logic       rstn_s2;
    logic       ten_s1;
    logic       ten_s2;
    logic       cke_prev;
    sdcad_pwr_t pwr;
    logic       cmd_valid;
    sdcad_cmd_t cmd;
    logic [1:0] bg;
    logic [1:0] ba;
    logic [17:0] addr;
    logic       auto_pre;
    logic       all_banks;
    logic       bc;
    logic       odt_on;
    logic       tdqs_on;
    logic [1:0] keep;
    logic       par_err;
    logic [3:0] alert_cnt;
    logic       test_mode;
  } sdcad_state_t;

endpackage

// *** common/sdcad_par_if.sv ***
/*
  Carrier between the decoder and its parity checker: the command word,
  the effective chip select and the check options, and the error back.
  Assumes both ends sit in one clock domain.
*/
`timescale 1ns/100ps
interface sdcad_par_if;
  sdcad_pkg::sdcad_cw_t cw;
  logic                 cs_eff;
  logic                 chk_en;
  logic                 use_cid;
  logic [17:0]          addr_used;
  logic                 err;

  modport top (output cw, cs_eff, chk_en, use_cid, addr_used, input err);
  modport chk (input cw, cs_eff, chk_en, use_cid, addr_used, output err);
endinterface

// *** verilog/sdcad_par_chk.sv ***
/*
  Even parity check over the registered command word.
  Assumes the word and options are stable for the whole cycle.
*/
`timescale 1ns/100ps
module sdcad_par_chk (
  // link to the decoder
  sdcad_par_if.chk pif
);
  logic [17:0] a_full;
  logic        cover_x;

  always_comb begin
    a_full  = {pif.cw.a17, pif.cw.ras_n, pif.cw.cas_n, pif.cw.we_n, pif.cw.addr}
              & pif.addr_used;
    cover_x = pif.cw.act_n ^ (^a_full) ^ (^pif.cw.bg) ^ (^pif.cw.ba)
              ^ (pif.use_cid & (^pif.cw.cid));
    pif.err = pif.chk_en & ~pif.cs_eff & (cover_x ^ pif.cw.par);
  end
endmodule

// *** dv/sdcad_ctrl_model.sv ***
/*
  Controller model: drives the command, address and control pins.
  Assumes the bench changes its requests just after the rising edge.
*/
`timescale 1ns/100ps
module sdcad_ctrl_model (
  // clock
  input  wire logic            clk,
  // requests from the bench
  input  wire logic            go,
  input  sdcad_pkg::sdcad_cw_t w,
  input  wire logic            rst_req,
  input  wire logic            ten_req,
  // pins
  output sdcad_pkg::sdcad_cw_t pins,
  output logic                 reset_n,
  output logic                 ten
);
  sdcad_pkg::sdcad_cw_t last_q;

  always_ff @(posedge clk) begin
    last_q <= pins;
  end

  // deselected: lines show the inverse of the last value, not a held one
  always_comb begin
    pins = go ? w : ~last_q;
    if (!go) begin
      pins.cs_n = 1'h1;
      pins.cke  = w.cke;
      pins.odt  = w.odt;
    end
  end

  assign reset_n = !rst_req;
  assign ten     = ten_req;
endmodule

// *** dv/sdcad_cmd_addr_input_decode_tb.sv ***
/*
  Self-checking bench of the command and address decoder.
  Assumes the controller model drives the pins; expectations come from
  the functions below.
*/
`timescale 1ns/100ps
`include "sdcad_defines.svh"
module sdram_cmd_addr_input_decode_tb;
  typedef sdcad_pkg::sdcad_cw_t cw_t;
  logic                  clk, rst, go, wr_beat, acc, cfg_par_en, cfg_rtt_en, cfg_dm_en;
  logic                  any_bank_open, rst_req, ten_req, reset_n, ten, cmd_valid;
  logic                  ap, ab, bc, ice, ibe, ode, odt_on, tq_on, par_err, alert_n;
  logic                  test_mode, in_rst, tdqs;
  logic [1:0]            wr_dm_n, cmd_bg, cmd_ba, beat_keep;
  logic [6:0]            nx;
  logic [17:0]           cmd_addr;
  logic [30:0]           hist[$];
  cw_t                   w, pins, x;
  sdcad_pkg::sdcad_cmd_t cmd;
  sdcad_pkg::sdcad_pwr_t pwr_state;
  sdcad_pkg::sdcad_stack_t stk;
  int                    err_total, samples_checked, quiet, seed, i, p;

  always #5 clk = ~clk;

  sdcad_ctrl_model i_ctrl (.clk(clk), .go(go), .w(w), .rst_req(rst_req), .ten_req(ten_req),
    .pins(pins), .reset_n(reset_n), .ten(ten));

  sdcad_top i_dut (.clk(clk), .rst(rst), .cs_n(pins.cs_n), .act_n(pins.act_n),
    .ras_n(pins.ras_n), .cas_n(pins.cas_n), .we_n(pins.we_n), .a17(pins.a17),
    .addr(pins.addr), .bg(pins.bg), .ba(pins.ba), .cid(pins.cid), .cke(pins.cke),
    .odt(pins.odt), .par(pins.par), .reset_n(reset_n), .ten(ten), .wr_beat(wr_beat),
    .wr_dm_n(wr_dm_n), .cfg_par_en(cfg_par_en), .cfg_rtt_en(cfg_rtt_en),
    .cfg_dm_en(cfg_dm_en), .cfg_tdqs_en(tdqs), .cfg_stack(stk),
    .cfg_die_id(3'h0), .cfg_ddp_die(1'h0), .any_bank_open(any_bank_open),
    .cmd_valid(cmd_valid), .cmd(cmd), .cmd_bg(cmd_bg), .cmd_ba(cmd_ba),
    .cmd_addr(cmd_addr), .cmd_auto_pre(ap), .cmd_all_banks(ab), .cmd_burst_chop(bc),
    .pwr_state(pwr_state), .int_clk_en(ice), .in_buf_en(ibe), .out_drv_en(ode),
    .odt_on(odt_on), .tdqs_term_on(tq_on), .beat_keep(beat_keep), .par_err(par_err),
    .alert_n(alert_n), .test_mode(test_mode), .dev_in_reset(in_rst));

  function automatic logic par_odd(input cw_t c);
    return ^{c.act_n, c.ras_n, c.cas_n, c.we_n, c.a17, c.addr, c.bg, c.ba, c.par,
             stk == sdcad_pkg::STK_3DS ? c.cid : 3'h0};
  endfunction

  function automatic cw_t mk(input logic a, input logic [2:0] c, input logic bad);
    cw_t r;
    r = 30'($urandom);
    r.cs_n = 1'h0;
    r.act_n = a;
    {r.ras_n, r.cas_n, r.we_n} = c;
    r.cid = 3'h0;
    r.cke = 1'h1;
    r.par = 1'h0;
    r.par = par_odd(r) ^ bad;
    return r;
  endfunction

  function automatic cw_t rnd();
    cw_t r;
    r = mk(1'($urandom_range(0, 1)), 3'($urandom_range(0, 6)), $urandom_range(0, 7) == 0);
    if ($urandom_range(0, 4) == 0) r.cs_n = 1'h1;
    return r;
  endfunction

  function automatic cw_t idl(input logic k, input logic o);
    cw_t r;
    r = `SDCAD_CW_IDLE;
    r.cke = k;
    r.odt = o;
    return r;
  endfunction

  function automatic sdcad_pkg::sdcad_cmd_t exp_cmd(input cw_t c);
    if (!c.act_n) return sdcad_pkg::CMD_ACT;
    case ({c.ras_n, c.cas_n, c.we_n})
      `SDCAD_RCW_MRS: return sdcad_pkg::CMD_MRS;
      `SDCAD_RCW_REF: return sdcad_pkg::CMD_REF;
      `SDCAD_RCW_PRE: return sdcad_pkg::CMD_PRE;
      `SDCAD_RCW_RFU: return sdcad_pkg::CMD_RFU;
      `SDCAD_RCW_WR:  return sdcad_pkg::CMD_WR;
      `SDCAD_RCW_RD:  return sdcad_pkg::CMD_RD;
      `SDCAD_RCW_ZQC: return sdcad_pkg::CMD_ZQC;
      default:        return sdcad_pkg::CMD_NOP;
    endcase
  endfunction

  function automatic logic [17:0] exp_addr(input cw_t c);
    return !c.act_n ? {c.a17, c.ras_n, c.cas_n, c.we_n, c.addr} : {c.a17, 3'h0, c.addr};
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // one word per edge; checks the word sent three edges before
  task automatic step(input cw_t c, input logic g);
    cw_t  e;
    logic ea, ek, bad, ok;
    @(posedge clk);
    ek = wr_beat & (wr_dm_n[0] | !cfg_dm_en | tdqs);
    w <= c;
    go <= g;
    wr_beat <= 1'($urandom_range(0, 1));
    wr_dm_n <= 2'($urandom_range(0, 3));
    {tdqs, cfg_par_en, cfg_rtt_en, cfg_dm_en, any_bank_open, rst_req, ten_req} <= nx;
    if (!g) c.cs_n = 1'h1;
    hist.push_back({acc, c});
    @(negedge clk);
    if (acc) check("beat_keep", beat_keep, {1'h0, ek});
    if (hist.size() > 3) begin
      {ea, e} = hist.pop_front();
      bad = ea & !e.cs_n & cfg_par_en & par_odd(e);
      ok = ea & !e.cs_n & !bad & (stk != sdcad_pkg::STK_3DS || e.cid == 3'h0);
      quiet = bad ? 0 : quiet + 1;
      check("par_err", par_err, bad);
      check("cmd_valid", cmd_valid, ok);
      if (quiet > 1 && quiet < 6) check("alert_n", alert_n, 1'h0);
      if (quiet > 9) check("alert_n", alert_n, 1'h1);
      if (ea) check("odt_on", odt_on, e.odt & cfg_rtt_en);
      if (ea) check("tdqs_term_on", tq_on, e.odt & cfg_rtt_en & tdqs);
      if (ok) begin
        check("cmd", cmd, exp_cmd(e));
        check("cmd_addr", cmd_addr, exp_addr(e));
        check("cmd_bg", cmd_bg, e.bg);
        check("cmd_ba", cmd_ba, e.ba);
        if (exp_cmd(e) inside {sdcad_pkg::CMD_RD, sdcad_pkg::CMD_WR}) begin
          check("auto_pre", ap, e.addr[`SDCAD_AP_BIT]);
          check("burst_chop", bc, !e.addr[`SDCAD_BC_BIT]);
        end
        if (exp_cmd(e) == sdcad_pkg::CMD_PRE) check("all_banks", ab, e.addr[`SDCAD_AP_BIT]);
      end
    end
  endtask

  task automatic pad(input int n);
    repeat (n) step(idl(1'h1, 1'h0), 1'h0);
  endtask

  task automatic refused(input int n, input logic k);
    cw_t r;
    repeat (n) begin
      r = mk(1'($urandom_range(0, 1)), 3'($urandom_range(0, 6)), 1'h0);
      r.cke = k;
      step(r, 1'h1);
    end
  endtask

  // bounded wait on power state (0), test mode (1) or pin reset (2)
  task automatic wait_on(input int sel, input logic [1:0] v, input cw_t c);
    logic [1:0] s;
    for (int k = 0; k < 12; k++) begin
      s = sel == 0 ? pwr_state : sel == 1 ? {1'h0, test_mode} : {1'h0, in_rst};
      if (s === v) return;
      step(c, 1'h0);
    end
    err_total++;
    report_and_stop();
  endtask

  initial begin
    clk = 1'h0;
    err_total = 0;
    samples_checked = 0;
    quiet = 20;
    seed = $urandom(52658);
    rst = 1'h1;
    go = 1'h1;
    w = idl(1'h1, 1'h0);
    nx = 7'h38;
    {tdqs, cfg_par_en, cfg_rtt_en, cfg_dm_en, any_bank_open, rst_req, ten_req} = nx;
    stk = sdcad_pkg::STK_NONE;
    wr_beat = 1'h0;
    wr_dm_n = 2'h3;
    acc = 1'h0;
    repeat (6) @(posedge clk);
    rst <= 1'h0;
    pad(6);
    acc = 1'h1;
    for (i = 0; i < 9; i++) step(mk(i != 8, i[2:0], 1'h0), 1'h1);
    step(mk(1'h1, `SDCAD_RCW_WR, 1'h1), 1'h1);
    for (p = 0; p < 4; p++) begin
      pad(4);
      nx[5:3] = {p != 1, p[0], p[1]};
      nx[6] = p[0];
      repeat (150) step(rnd(), 1'h1);
    end
    // single-load stack: only words with this die's chip ID are taken
    pad(4);
    stk = sdcad_pkg::STK_3DS;
    repeat (40) begin
      x = rnd();
      x.cid = $urandom_range(0, 1) ? 3'h3 : 3'h0;
      step(x, 1'h1);
    end
    pad(4);
    stk = sdcad_pkg::STK_NONE;
    for (p = 0; p < 2; p++) begin
      pad(4);
      nx[2] = p[0];
      acc = 1'h0;
      wait_on(0, p == 1 ? sdcad_pkg::PWR_APD : sdcad_pkg::PWR_PPD, idl(1'h0, 1'h0));
      check("int_clk_en", ice, 1'h0);
      check("in_buf_en", ibe, 1'h0);
      check("out_drv_en", ode, 1'h0);
      refused(4, 1'h0);
      wait_on(0, sdcad_pkg::PWR_ON, idl(1'h1, 1'h0));
      check("int_clk_en", ice, 1'h1);
      check("in_buf_en", ibe, 1'h1);
      check("out_drv_en", ode, 1'h1);
      pad(4);
      acc = 1'h1;
    end
    nx[2] = 1'h0;
    pad(4);
    acc = 1'h0;
    x = mk(1'h1, `SDCAD_RCW_REF, 1'h0);
    x.cke = 1'h0;
    step(x, 1'h1);
    wait_on(0, sdcad_pkg::PWR_SR, idl(1'h0, 1'h1));
    repeat (3) step(idl(1'h0, 1'h1), 1'h0);
    check("odt_on", odt_on, 1'h0);
    wait_on(0, sdcad_pkg::PWR_ON, idl(1'h1, 1'h0));
    pad(4);
    nx[0] = 1'h1;
    wait_on(1, 2'h1, idl(1'h1, 1'h0));
    refused(4, 1'h1);
    nx[0] = 1'h0;
    wait_on(1, 2'h0, idl(1'h1, 1'h0));
    nx[1] = 1'h1;
    wait_on(2, 2'h1, idl(1'h1, 1'h0));
    refused(4, 1'h1);
    check("alert_n", alert_n, 1'h1);
    nx[1] = 1'h0;
    wait_on(2, 2'h0, idl(1'h1, 1'h0));
    pad(6);
    acc = 1'h1;
    repeat (20) step(rnd(), 1'h1);
    pad(4);
    report_and_stop();
  end
endmodule
